// ===== src/peiu_top.sv
`timescale 1ns/1ps
// Functional notes
// - Test bit forces interrupt while set
// - Global gate allows event-based interrupts
// - Control bit 0 selects pin role
// - Control bits 15:3 ignore writes, read zero
// - Status latches events regardless of enables
// - Event interrupt on the pin needs enable, gate and output enable
// - Reading status clears returned pending bits
// - Status bits 15..11 quality, energy, link, speed, duplex
// - Bits 10..8 autoneg, false-carrier half, rx-error half
// - Enables 7:0 gate status bit plus eight
// - Summary pending bit, follows test force or gated enabled status
// - False-carrier counter eight bits, saturating
module peiu_top
    import peiu_pkg::*;
(
    // Clock and reset
    input  wire logic                   i_clock,
    input  wire logic                   i_rst_n,
    // Management register port
    input  wire logic [4:0]             i_reg_addr,
    input  wire logic                   i_reg_wr,
    input  wire logic                   i_reg_rd,
    input  wire logic [REG_WIDTH-1:0]   i_reg_wdata,
    output logic [REG_WIDTH-1:0]        o_reg_rdata,
    output logic                        o_reg_rvalid,
    // Event pulses from the detectors
    input  wire logic                   i_energy_change,
    input  wire logic                   i_link_change,
    input  wire logic                   i_speed_change,
    input  wire logic                   i_duplex_change,
    input  wire logic                   i_autoneg_done,
    input  wire logic                   i_link_quality,
    input  wire logic                   i_false_carrier,
    input  wire logic                   i_rx_error,
    // Shared power-down or interrupt pin
    input  wire logic                   i_powerdown_or_irq_pin,
    output logic                        o_powerdown_or_irq_pin,
    output logic                        o_powerdown_or_irq_pin_oe,
    // Status toward the rest of the transceiver
    output logic                        o_powerdown_req,
    output logic                        o_summary_irq_pending
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [2:0]                 ctrl_q;
    logic [EVENT_COUNT-1:0]     enable_q;
    logic [EVENT_COUNT-1:0]     status_q;
    logic [EVENT_COUNT-1:0]     status_d;
    logic [REG_WIDTH-1:0]       rdata_q;
    logic                       rvalid_q;
    logic                       pin_q;
    logic                       pin_oe_q;
    logic                       pending_q;
    logic                       pdn_q;
    logic [2:0]                 pin_sync_q;
    logic [CNT_WIDTH-1:0]       false_cnt;
    logic [CNT_WIDTH-1:0]       rxerr_cnt;
    logic                       false_half;
    logic                       rxerr_half;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [4:0] addr, input logic [4:0] target);
        hit = (addr == target);
    endfunction

    wire logic wr_ctrl   = i_reg_wr && hit(i_reg_addr, ADDR_CONTROL);
    wire logic wr_en     = i_reg_wr && hit(i_reg_addr, ADDR_STATUS_EN);
    wire logic rd_stat   = i_reg_rd && hit(i_reg_addr, ADDR_STATUS_EN);
    wire logic rd_false  = i_reg_rd && hit(i_reg_addr, ADDR_FALSE_CNT);
    wire logic rd_rxerr  = i_reg_rd && hit(i_reg_addr, ADDR_RXERR_CNT);

    wire logic pin_irq_oe   = ctrl_q[CTRL_PIN_IRQ_OE_BIT];
    wire logic event_gate   = ctrl_q[CTRL_EVENT_GATE_BIT];
    wire logic test_force   = ctrl_q[CTRL_TEST_FORCE_BIT];

    // ------------------------------------------------------------
    // Event collection
    // ------------------------------------------------------------
    wire logic [EVENT_COUNT-1:0] events = {
        i_link_quality,
        i_energy_change,
        i_link_change,
        i_speed_change,
        i_duplex_change,
        i_autoneg_done,
        false_half,
        rxerr_half
    };

    // Read clears, a new event in the same cycle wins
    assign status_d = (rd_stat ? STAT_RESET : status_q) | events;

    wire logic event_irq = event_gate && |(status_q & enable_q);
    wire logic irq_cond  = test_force || event_irq;
    wire logic irq_out   = pin_irq_oe && irq_cond;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire logic [REG_WIDTH-1:0] rd_mux =
        hit(i_reg_addr, ADDR_CONTROL)   ? {13'h0000, ctrl_q} :
        hit(i_reg_addr, ADDR_STATUS_EN) ? {status_q, enable_q} :
        hit(i_reg_addr, ADDR_FALSE_CNT) ? {8'h00, false_cnt} :
        hit(i_reg_addr, ADDR_RXERR_CNT) ? {8'h00, rxerr_cnt} :
                                          RDATA_RESET;

    // ------------------------------------------------------------
    // Error counters
    // ------------------------------------------------------------
    peiu_sat_counter #(
        .WIDTH        (CNT_WIDTH)
    ) u_false_cnt (
        .i_clock      (i_clock),
        .i_rst_n      (i_rst_n),
        .i_inc        (i_false_carrier),
        .i_clear      (rd_false),
        .o_count      (false_cnt),
        .o_half_event (false_half)
    );

    peiu_sat_counter #(
        .WIDTH        (CNT_WIDTH)
    ) u_rxerr_cnt (
        .i_clock      (i_clock),
        .i_rst_n      (i_rst_n),
        .i_inc        (i_rx_error),
        .i_clear      (rd_rxerr),
        .o_count      (rxerr_cnt),
        .o_half_event (rxerr_half)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q   <= CTRL_RESET;
            enable_q <= EN_RESET;
            status_q <= STAT_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= i_reg_wdata[CTRL_USED_BITS-1:0];
            end
            if (wr_en) begin
                enable_q <= i_reg_wdata[EVENT_COUNT-1:0];
            end
            status_q <= status_d;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q  <= RDATA_RESET;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= i_reg_rd;
            if (i_reg_rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin and summary
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_sync_q <= 3'h7;
            pin_q      <= 1'b1;
            pin_oe_q   <= 1'b0;
            pending_q  <= 1'b0;
            pdn_q      <= 1'b0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], i_powerdown_or_irq_pin};
            pin_q      <= !irq_out;
            pin_oe_q   <= pin_irq_oe;
            pending_q  <= irq_cond;
            if (!pin_irq_oe) begin
                if (pin_sync_q[2] == pin_sync_q[1]) begin
                    pdn_q <= !pin_sync_q[2];
                end
            end else begin
                pdn_q <= 1'b0;
            end
        end
    end

    assign o_reg_rdata               = rdata_q;
    assign o_reg_rvalid              = rvalid_q;
    assign o_powerdown_or_irq_pin    = pin_q;
    assign o_powerdown_or_irq_pin_oe = pin_oe_q;
    assign o_powerdown_req           = pdn_q;
    assign o_summary_irq_pending     = pending_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_test_force_irq: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        test_force && pin_irq_oe |=> !o_powerdown_or_irq_pin && o_summary_irq_pending)
        else $error("test force did not raise the interrupt");

    a_gate_blocks_irq: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !event_gate && !test_force |=> o_powerdown_or_irq_pin && !o_summary_irq_pending)
        else $error("interrupt raised with gate closed");

    a_pin_role_oe: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        ##1 o_powerdown_or_irq_pin_oe == $past(ctrl_q[CTRL_PIN_IRQ_OE_BIT]))
        else $error("pin enable does not follow control bit");

    a_ctrl_reserved_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_reg_rd && hit(i_reg_addr, ADDR_CONTROL) |=> o_reg_rvalid && o_reg_rdata[15:3] == 13'h0000)
        else $error("reserved control bits read nonzero");

    a_event_latched: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        |events |=> (status_q & $past(events)) == $past(events))
        else $error("event not latched in status");

    a_enable_gates_irq: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !test_force && (!pin_irq_oe || !(|(status_q & enable_q))) |=> o_powerdown_or_irq_pin)
        else $error("interrupt without enabled pending event");

    a_read_clears: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        rd_stat && !(|events) |=> status_q == STAT_RESET)
        else $error("status not cleared by read");

    a_status_layout: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        rd_stat |=> o_reg_rdata[15:8] == $past(status_q) && o_reg_rdata[7:0] == $past(enable_q))
        else $error("status read data misplaced");

    a_autoneg_bit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_autoneg_done |=> status_q[EV_AUTONEG_DONE] ##1 (status_q[EV_AUTONEG_DONE] || $past(rd_stat)))
        else $error("autoneg event not held in bit 10");

    a_enable_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        wr_en |=> enable_q == $past(i_reg_wdata[7:0]))
        else $error("enable write lost");

    a_summary_holds: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        event_gate && |(status_q & enable_q) |=> o_summary_irq_pending)
        else $error("summary pending not shown");

    a_pin_release: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        pin_irq_oe && irq_cond |=> !o_powerdown_or_irq_pin ##1 (o_powerdown_or_irq_pin || $past(irq_out)))
        else $error("pin not driven low for interrupt");

    a_ctrl_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        wr_ctrl |=> ctrl_q == $past(i_reg_wdata[CTRL_USED_BITS-1:0]))
        else $error("control write lost");

    a_status_no_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        wr_en && !rd_stat && !(|events) |=> status_q == $past(status_q))
        else $error("status changed by a write");

    a_set_beats_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        rd_stat && |events |=> status_q == $past(events))
        else $error("event lost against a status read");

    a_status_sticky: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !rd_stat |=> (status_q & $past(status_q)) == $past(status_q))
        else $error("pending status dropped without a read");

    a_link_change_bit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_link_change |=> status_q[EV_LINK_CHANGE])
        else $error("link event not held in bit 13");

    a_quality_bit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_link_quality |=> status_q[EV_LINK_QUALITY])
        else $error("quality event not held in bit 15");

    a_energy_bit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_energy_change |=> status_q[EV_ENERGY_CHANGE])
        else $error("energy event not held in bit 14");

    a_false_half_bit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        false_half |=> status_q[EV_FALSE_CARR_HALF])
        else $error("false carrier half event not held in bit 9");

    a_rxerr_half_bit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        rxerr_half |=> status_q[EV_RX_ERROR_HALF])
        else $error("rx error half event not held in bit 8");

    a_pin_input_role: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !pin_irq_oe |=> o_powerdown_or_irq_pin && !o_powerdown_or_irq_pin_oe)
        else $error("pin driven while in power down role");

    a_pdn_irq_role: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        pin_irq_oe |=> !o_powerdown_req)
        else $error("power down request while pin is an output");

    a_pending_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !test_force && !event_irq |=> !o_summary_irq_pending)
        else $error("summary pending without a cause");

    a_count_read_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_reg_rd && hit(i_reg_addr, ADDR_FALSE_CNT) |=> o_reg_rdata[15:8] == 8'h00)
        else $error("counter read upper byte nonzero");

endmodule

// ===== src/peiu_pkg.sv
package peiu_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_CONTROL    = 5'h11;
    localparam logic [4:0] ADDR_STATUS_EN  = 5'h12;
    localparam logic [4:0] ADDR_FALSE_CNT  = 5'h14;
    localparam logic [4:0] ADDR_RXERR_CNT  = 5'h15;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int CTRL_PIN_IRQ_OE_BIT  = 0;
    localparam int CTRL_EVENT_GATE_BIT  = 1;
    localparam int CTRL_TEST_FORCE_BIT  = 2;
    localparam int CTRL_USED_BITS       = 3;

    // ------------------------------------------------------------
    // Status and enable layout, event index = status bit - 8
    // ------------------------------------------------------------
    localparam int EVENT_COUNT          = 8;
    localparam int STATUS_LSB           = 8;
    localparam int EV_RX_ERROR_HALF     = 0;
    localparam int EV_FALSE_CARR_HALF   = 1;
    localparam int EV_AUTONEG_DONE      = 2;
    localparam int EV_DUPLEX_CHANGE     = 3;
    localparam int EV_SPEED_CHANGE      = 4;
    localparam int EV_LINK_CHANGE       = 5;
    localparam int EV_ENERGY_CHANGE     = 6;
    localparam int EV_LINK_QUALITY      = 7;

    // ------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------
    localparam int          REG_WIDTH   = 16;
    localparam int          CNT_WIDTH   = 8;
    localparam logic [2:0]  CTRL_RESET  = 3'h0;
    localparam logic [7:0]  EN_RESET    = 8'h00;
    localparam logic [7:0]  STAT_RESET  = 8'h00;
    localparam logic [15:0] RDATA_RESET = 16'h0000;

endpackage

// ===== src/peiu_sat_counter.sv
`timescale 1ns/1ps
module peiu_sat_counter
    import peiu_pkg::*;
#(
    parameter int WIDTH = CNT_WIDTH
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    // Event and clear-on-read
    input  wire logic             i_inc,
    input  wire logic             i_clear,
    // Count and half-full pulse
    output logic [WIDTH-1:0]      o_count,
    output logic                  o_half_event
);

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic             half_q;
    wire  logic       at_max  = &count_q;
    wire  logic       msb_d;

    // ------------------------------------------------------------
    // Saturating count, clear takes the old value away
    // ------------------------------------------------------------
    always_comb begin
        if (i_clear) begin
            count_d = {{(WIDTH-1){1'b0}}, i_inc};
        end else if (i_inc && !at_max) begin
            count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end else begin
            count_d = count_q;
        end
    end

    assign msb_d = count_d[WIDTH-1];

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_q <= '0;
            half_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            half_q  <= msb_d && !count_q[WIDTH-1];
        end
    end

    assign o_count      = count_q;
    assign o_half_event = half_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_count_sticks_max: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        at_max && !i_clear |=> &count_q)
        else $error("counter left its maximum without a clear");

    a_half_once: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        half_q |-> count_q[WIDTH-1] && !$past(count_q[WIDTH-1]))
        else $error("half-full event without msb rising");

endmodule

// ===== bench/peiu_mgmt_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Station manager model on the register port
// ------------------------------------------------------------
module peiu_mgmt_model
    import peiu_pkg::*;
(
    // Clock
    input  wire logic                   i_clock,
    // Answer from the block
    input  wire logic [REG_WIDTH-1:0]   i_reg_rdata,
    input  wire logic                   i_reg_rvalid,
    // Requests to the block
    output logic [4:0]                  o_reg_addr,
    output logic                        o_reg_wr,
    output logic                        o_reg_rd,
    output logic [REG_WIDTH-1:0]        o_reg_wdata
);
    initial begin
        o_reg_addr  = 5'h00;
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
        o_reg_wdata = 16'h0000;
    end

    // One-cycle write strobe, no answer
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clock);
        o_reg_addr  <= a;
        o_reg_wdata <= d;
        o_reg_wr    <= 1'b1;
        @(posedge i_clock);
        o_reg_wr    <= 1'b0;
        o_reg_wdata <= ~d;
    endtask

    // Read strobe, then bounded wait for the valid pulse
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
        int n;
        ok = 1'b0;
        d  = 16'hXXXX;
        @(posedge i_clock);
        o_reg_addr <= a;
        o_reg_rd   <= 1'b1;
        @(posedge i_clock);
        o_reg_rd   <= 1'b0;
        #1;
        for (n = 0; n < 4 && !ok; n++) begin
            if (i_reg_rvalid === 1'b1) begin
                ok = 1'b1;
                d  = i_reg_rdata;
            end else begin
                @(posedge i_clock);
                #1;
            end
        end
    endtask
endmodule

// ===== bench/phy_event_interrupt_unit_tb.sv
`timescale 1ns/1ps
module phy_event_interrupt_unit_tb
    import peiu_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  ev = 8'h00;
    logic        pd_drive = 1'b1;
    logic [4:0]  addr;
    logic        wr, rd, rvalid, pin_o, pin_oe, pd_req, pend, pin_wire;
    logic [15:0] wdata, rdata;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          i;

    always #12.5 clk = ~clk;
    assign pin_wire = pin_oe ? pin_o : pd_drive;

    peiu_mgmt_model MGMT (.i_clock(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
        .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wdata));

    peiu_top DUT (.i_clock(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_energy_change(ev[6]), .i_link_change(ev[5]), .i_speed_change(ev[4]),
        .i_duplex_change(ev[3]), .i_autoneg_done(ev[2]), .i_link_quality(ev[7]),
        .i_false_carrier(ev[1]), .i_rx_error(ev[0]), .i_powerdown_or_irq_pin(pin_wire),
        .o_powerdown_or_irq_pin(pin_o), .o_powerdown_or_irq_pin_oe(pin_oe),
        .o_powerdown_req(pd_req), .o_summary_irq_pending(pend));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            mismatches++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        MGMT.rd(a, d, ok);
        check({15'h0000, ok}, 16'h0001);
        check(d, exp);
    endtask

    // Event held high for n cycles gives n samples
    task automatic pulse(input int idx, input int n);
        @(posedge clk);
        ev[idx] <= 1'b1;
        repeat (n) @(posedge clk);
        ev[idx] <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // Pin level, drive enable, pending summary
    task automatic pins(input logic [2:0] exp);
        check({13'h0000, pin_o, pin_oe, pend}, {13'h0000, exp});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        pins(3'b100);
        rd_chk(ADDR_CONTROL, 16'h0000);
        rd_chk(ADDR_STATUS_EN, 16'h0000);
        MGMT.wr(ADDR_CONTROL, 16'hFFF8);
        rd_chk(ADDR_CONTROL, 16'h0000);
        MGMT.wr(ADDR_STATUS_EN, 16'hFFFF);
        rd_chk(ADDR_STATUS_EN, 16'h00FF);
        MGMT.wr(ADDR_STATUS_EN, 16'h0000);
        rd_chk(5'h1F, 16'h0000);
        for (i = 2; i < 8; i++) begin
            pulse(i, 1);
            rd_chk(ADDR_STATUS_EN, 16'h0001 << (i + 8));
            rd_chk(ADDR_STATUS_EN, 16'h0000);
        end
        pulse(1, 300);
        rd_chk(ADDR_STATUS_EN, 16'h0200);
        rd_chk(ADDR_STATUS_EN, 16'h0000);
        rd_chk(ADDR_FALSE_CNT, 16'h00FF);
        rd_chk(ADDR_FALSE_CNT, 16'h0000);
        pulse(0, 127);
        rd_chk(ADDR_STATUS_EN, 16'h0000);
        pulse(0, 1);
        rd_chk(ADDR_STATUS_EN, 16'h0100);
        rd_chk(ADDR_RXERR_CNT, 16'h0080);
        MGMT.wr(ADDR_STATUS_EN, 16'h0020);
        MGMT.wr(ADDR_CONTROL, 16'h0001);
        pulse(5, 1);
        pins(3'b110);
        MGMT.wr(ADDR_CONTROL, 16'h0003);
        repeat (3) @(posedge clk);
        #1;
        pins(3'b011);
        rd_chk(ADDR_CONTROL, 16'h0003);
        pins(3'b011);
        rd_chk(ADDR_STATUS_EN, 16'h2020);
        repeat (2) @(posedge clk);
        #1;
        pins(3'b110);
        pulse(4, 1);
        pins(3'b110);
        rd_chk(ADDR_STATUS_EN, 16'h1020);
        MGMT.wr(ADDR_CONTROL, 16'h0002);
        pulse(5, 1);
        pins(3'b101);
        rd_chk(ADDR_STATUS_EN, 16'h2020);
        MGMT.wr(ADDR_CONTROL, 16'h0005);
        repeat (3) @(posedge clk);
        #1;
        pins(3'b011);
        rd_chk(ADDR_STATUS_EN, 16'h0020);
        repeat (4) @(posedge clk);
        #1;
        pins(3'b011);
        @(posedge clk);
        pd_drive <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check({15'h0000, pd_req}, 16'h0000);
        MGMT.wr(ADDR_CONTROL, 16'h0000);
        repeat (8) @(posedge clk);
        #1;
        pins(3'b100);
        check({15'h0000, pd_req}, 16'h0001);
        @(posedge clk);
        pd_drive <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        check({15'h0000, pd_req}, 16'h0000);
        end_of_test();
    end
endmodule
